/* File: hdl/bus_arb_pkg.sv */
// Purpose: constants and carrier types for the shared bus arbiter
// Assumes: 10 MHz system clock, synchronous active-high reset
// Notes: pin levels are carried active low where the pin is active low
//
// Functional notes
// RULE1 - Host request makes master yield, then grant
// RULE2 - Yielding floats address, data, selects, strobes
// RULE3 - Host request beats every peer request
// RULE4 - Grant held until host withdraws request
// RULE5 - Only current master drives host grant
// RULE6 - Host asserts chip select to address device
// RULE7 - Ack low inserts waits during host access
// RULE8 - Ack driven only with select and request
// RULE9 - Ack open drain until drive bit set
// RULE10 - Drive only own request line, monitor others
// RULE11 - Index one maps line one; zero single
// RULE12 - Index inputs static or changed in reset
// RULE13 - Priority select high rotates, low fixed
// RULE14 - Priority select equal and changed together
// RULE15 - Core priority preempts background DMA traffic
// RULE16 - Fixed priority favours lowest index, identically
package bus_arb_pkg;
  localparam int unsigned NUM_PEERS = 6;
  localparam int unsigned INDEX_W = 3;
  localparam logic [2:0] INDEX_SINGLE = 3'h0;
  localparam logic [2:0] LAST_INIT = 3'h0;
  localparam logic [2:0] MASTER_NONE = 3'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_REQ = 3'b001,
    ST_MASTER = 3'b010,
    ST_YIELD = 3'b011,
    ST_HOST = 3'b100
  } arb_state_t;

  // Bus-facing pin pair of a two-way or open-drain line
  typedef struct packed {
    logic o;
    logic oe;
  } pin_drive_t;

  // Host access request towards the memory side
  typedef struct packed {
    logic cs_n;
    logic hbr_n;
  } host_sel_t;
endpackage

/* File: hdl/bus_arbiter.sv */
// Purpose: distributed bus arbitration between peers and a host
// Assumes: all inputs synchronous to i_sys_clk; request, select and grant pins are active low
// Notes: every processor runs the same decision from the same request lines
`timescale 1ns/1ns
`default_nettype none
module bus_arbiter #(
  parameter int unsigned NUM_PEERS = bus_arb_pkg::NUM_PEERS
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // Configuration
  input wire logic [2:0] i_processor_index,
  input wire logic i_rotating_priority_select,
  input wire logic i_ack_drive_mode_bit,
  // Local core side
  input wire logic i_core_bus_want,
  input wire logic i_core_is_dma,
  input wire logic i_core_priority_req,
  input wire logic i_access_done,
  output logic o_bus_owner,
  output logic o_bus_drive_en,
  // Peer request lines
  input wire logic [NUM_PEERS-1:0] i_peer_bus_request_n,
  output logic [NUM_PEERS-1:0] o_peer_bus_request_n,
  output logic [NUM_PEERS-1:0] o_peer_bus_request_oe,
  // Shared core priority line, open drain
  input wire logic i_core_priority_override_n,
  output logic o_core_priority_override_n,
  output logic o_core_priority_override_oe,
  // Host side
  input wire logic i_host_bus_request_n,
  input wire logic i_host_chip_select_n,
  input wire logic i_host_bus_grant_n,
  output logic o_host_bus_grant_n,
  output logic o_host_bus_grant_oe,
  output logic o_host_access_ack,
  output logic o_host_access_ack_oe,
  output logic o_host_access_pending
);

  // A 3-bit index names at most seven request lines
  generate
    if (NUM_PEERS < 1 || NUM_PEERS > 7) begin : g_bad_peers
      $error("NUM_PEERS must be 1..7");
    end
  endgenerate

  bus_arb_pkg::arb_state_t state_q, state_d;
  logic [2:0] last_q;
  logic master_q;
  logic [NUM_PEERS-1:0] req_vec;
  logic [NUM_PEERS-1:0] own_line;
  logic [2:0] winner;
  logic win_valid;
  logic single;
  logic host_req;
  bus_arb_pkg::host_sel_t hsel;
  logic cpa_seen;
  logic ack_q;
  logic grant_q;
  logic [2:0] cur_q;
  logic cur_free;
  logic host_busy;

  assign single = (i_processor_index == bus_arb_pkg::INDEX_SINGLE); // [RULE11]
  assign host_req = ~i_host_bus_request_n;
  assign hsel.cs_n = i_host_chip_select_n;
  assign hsel.hbr_n = i_host_bus_request_n;
  assign cpa_seen = ~i_core_priority_override_n;
  // Host owns the bus while it requests or its grant is still seen low
  assign host_busy = host_req || ~i_host_bus_grant_n;

  // One-hot own line; index k selects bit k-1 (bit 0 is line one)
  genvar g;
  generate
    for (g = 0; g < NUM_PEERS; g++) begin : g_line
      assign own_line[g] = (i_processor_index == 3'(g + 1)); // [RULE11]
      // Observed lines, own line taken from our own drive
      assign req_vec[g] = own_line[g] ? (state_q == bus_arb_pkg::ST_REQ ||
                                         master_q) : ~i_peer_bus_request_n[g];
      assign o_peer_bus_request_oe[g] = own_line[g]; // [RULE10]
      assign o_peer_bus_request_n[g] = ~(own_line[g] &&
        (state_q == bus_arb_pkg::ST_REQ || master_q)); // [RULE10]
    end
  endgenerate

  // Winner pick: fixed lowest index, or rotating after last master
  always_comb begin
    logic [2:0] idx;
    logic [3:0] sum;
    idx = 3'h0;
    sum = 4'h0;
    winner = 3'h0;
    win_valid = 1'b0;
    for (int k = NUM_PEERS - 1; k >= 0; k--) begin
      if (i_rotating_priority_select) begin // [RULE13]
        sum = 4'(last_q) + 4'(k);
        idx = (sum >= 4'(NUM_PEERS)) ? 3'(sum - 4'(NUM_PEERS)) : 3'(sum);
      end else begin
        idx = 3'(k); // [RULE16]
      end
      if (req_vec[idx]) begin
        winner = idx + 3'h1;
        win_valid = 1'b1;
      end
    end
  end

  // Bus stays with the current master until its request line is released
  always_comb begin
    cur_free = 1'b1;
    for (int k = 0; k < NUM_PEERS; k++) begin
      if (cur_q == 3'(k + 1) && req_vec[k]) begin
        cur_free = 1'b0;
      end
    end
  end

  // Current master number, none while the bus is free; kept during host tenure
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      cur_q <= bus_arb_pkg::MASTER_NONE;
    end else if (cur_free && !host_busy) begin
      cur_q <= win_valid ? winner : bus_arb_pkg::MASTER_NONE; // [RULE16]
    end
  end

  // Mastership state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      bus_arb_pkg::ST_IDLE: begin
        if (host_busy) begin
          state_d = bus_arb_pkg::ST_IDLE; // [RULE3]
        end else if (i_core_bus_want) begin
          state_d = single ? bus_arb_pkg::ST_MASTER : bus_arb_pkg::ST_REQ;
        end
      end
      bus_arb_pkg::ST_REQ: begin
        if (!host_busy && cur_free && win_valid && winner == i_processor_index) begin
          state_d = bus_arb_pkg::ST_MASTER; // [RULE3] [RULE16]
        end else if (!i_core_bus_want) begin
          state_d = bus_arb_pkg::ST_IDLE;
        end
      end
      bus_arb_pkg::ST_MASTER: begin
        if (host_req) begin
          state_d = bus_arb_pkg::ST_YIELD; // [RULE1]
        end else if (i_core_is_dma && cpa_seen && !i_core_priority_req) begin
          state_d = bus_arb_pkg::ST_IDLE; // [RULE15]
        end else if (!i_core_bus_want && i_access_done) begin
          state_d = bus_arb_pkg::ST_IDLE;
        end
      end
      bus_arb_pkg::ST_YIELD: begin
        state_d = host_req ? bus_arb_pkg::ST_HOST : bus_arb_pkg::ST_IDLE; // [RULE1]
      end
      bus_arb_pkg::ST_HOST: begin
        if (!host_req) begin
          state_d = bus_arb_pkg::ST_IDLE; // [RULE4]
        end
      end
      default: state_d = bus_arb_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state_q <= bus_arb_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Master flag stays set through host tenure: we own the grant line
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      master_q <= 1'b0;
    end else begin
      master_q <= (state_d == bus_arb_pkg::ST_MASTER) ||
                  (state_d == bus_arb_pkg::ST_YIELD) ||
                  (state_d == bus_arb_pkg::ST_HOST && master_q);
    end
  end

  // Rotation pointer follows the last granted line
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      last_q <= bus_arb_pkg::LAST_INIT;
    end else if (win_valid && cur_free && !host_busy) begin
      last_q <= (winner >= 3'(NUM_PEERS)) ? 3'h0 : winner; // [RULE13]
    end
  end

  // Host grant: asserted after the yield, held while request stays
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      grant_q <= 1'b0;
    end else begin
      grant_q <= (state_d == bus_arb_pkg::ST_HOST) && master_q; // [RULE1] [RULE4]
    end
  end

  assign o_host_bus_grant_n = ~grant_q;
  assign o_host_bus_grant_oe = master_q; // [RULE5]
  assign o_bus_owner = (state_q == bus_arb_pkg::ST_MASTER);
  // Bus float while not owner, including the yield cycle
  assign o_bus_drive_en = (state_q == bus_arb_pkg::ST_MASTER) && !host_req; // [RULE2]

  // Core priority line, open drain: pull low while our core needs the bus as slave
  assign o_core_priority_override_n = 1'b0;
  assign o_core_priority_override_oe = i_core_priority_req &&
                                       (state_q == bus_arb_pkg::ST_REQ); // [RULE15]

  // Host access acknowledge: low while the access is not yet complete
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      ack_q <= 1'b0;
    end else if (hsel.cs_n || hsel.hbr_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= i_access_done; // [RULE7]
    end
  end

  assign o_host_access_ack = ack_q;
  assign o_host_access_pending = !hsel.cs_n && !hsel.hbr_n;
  // Open drain drives only the low level unless active drive selected
  assign o_host_access_ack_oe = o_host_access_pending &&
                                (i_ack_drive_mode_bit || !ack_q); // [RULE8] [RULE9]

endmodule
`default_nettype wire

/* File: verification/bus_arbiter_assertions.sv */
// Purpose: port checks for bus_arbiter
// Assumes: one clock, sync reset
// Notes: bound into every bus_arbiter
`timescale 1ns/1ns
`default_nettype none
module bus_arbiter_assertions #(
  parameter int unsigned NUM_PEERS = bus_arb_pkg::NUM_PEERS
) (
  // Watched ports
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic [2:0] i_processor_index,
  input wire logic i_ack_drive_mode_bit,
  input wire logic i_access_done,
  input wire logic i_host_bus_request_n,
  input wire logic i_host_chip_select_n,
  input wire logic o_bus_owner,
  input wire logic o_bus_drive_en,
  input wire logic [NUM_PEERS-1:0] o_peer_bus_request_oe,
  input wire logic o_host_bus_grant_n,
  input wire logic o_host_bus_grant_oe,
  input wire logic o_host_access_ack,
  input wire logic o_host_access_ack_oe,
  input wire logic o_host_access_pending
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_srst);
  sequence s_yield;
    o_bus_owner && !i_host_bus_request_n ##1 !i_host_bus_request_n;
  endsequence
  sequence s_done;
    o_host_access_pending && i_access_done ##1 o_host_access_pending;
  endsequence
  a_grant_after_yield: assert property (s_yield |=> !o_host_bus_grant_n)
    else $error("grant late");
  a_yield_floats: assert property (!i_host_bus_request_n |-> !o_bus_drive_en)
    else $error("bus driven");
  a_host_wins: assert property (!i_host_bus_request_n && !o_bus_owner |=> !o_bus_owner)
    else $error("peer beat host");
  a_grant_holds: assert property (!o_host_bus_grant_n && !i_host_bus_request_n |=> !o_host_bus_grant_n)
    else $error("grant lost");
  a_grant_drops: assert property (!o_host_bus_grant_n && i_host_bus_request_n |=> o_host_bus_grant_n)
    else $error("grant kept");
  a_grant_by_master: assert property (!o_host_bus_grant_n |-> o_host_bus_grant_oe)
    else $error("grant without master");
  a_ack_ready: assert property (s_done |-> o_host_access_ack)
    else $error("ack late");
  a_ack_select: assert property (o_host_access_ack_oe |-> o_host_access_pending && !i_host_chip_select_n && !i_host_bus_request_n)
    else $error("ack driven");
  a_ack_open: assert property (!i_ack_drive_mode_bit && o_host_access_ack_oe |-> !o_host_access_ack)
    else $error("ack drove high");
  a_req_line: assert property (i_processor_index != 3'h0 |-> o_peer_bus_request_oe == (NUM_PEERS'(1) << (i_processor_index - 3'h1)))
    else $error("wrong line");
endmodule
bind bus_arbiter bus_arbiter_assertions #(.NUM_PEERS(NUM_PEERS)) bus_arbiter_assertions_inst (
  .i_sys_clk, .i_srst, .i_processor_index, .i_ack_drive_mode_bit, .i_access_done,
  .i_host_bus_request_n, .i_host_chip_select_n, .o_bus_owner, .o_bus_drive_en,
  .o_peer_bus_request_oe, .o_host_bus_grant_n, .o_host_bus_grant_oe, .o_host_access_ack,
  .o_host_access_ack_oe,
  .o_host_access_pending);
`default_nettype wire

/* File: verification/peer_procs_model.sv */
// Purpose: peers and host wiring around one arbiter
// Assumes: released lines are pulled high
// Notes: peers assert only their own line
`timescale 1ns/1ns
`default_nettype none
module peer_procs_model (
  // Peer stimulus
  input wire logic [5:0] i_want,
  input wire logic i_prio,
  // Arbiter pin drives
  input wire logic [5:0] i_req_n,
  input wire logic [5:0] i_req_oe,
  input wire logic i_prio_oe,
  input wire logic i_prio_val,
  input wire logic i_grant_n,
  input wire logic i_grant_oe,
  // Resolved lines
  output logic [5:0] o_req_n,
  output logic o_prio_n,
  output logic o_grant_n
);
  assign o_req_n = ~(i_want | (i_req_oe & ~i_req_n));
  assign o_prio_n = ~(i_prio | (i_prio_oe & ~i_prio_val));
  assign o_grant_n = i_grant_oe ? i_grant_n : 1'b1;
endmodule
`default_nettype wire

/* File: verification/test_host_multiproc_bus_arbitration.sv */
// Purpose: self-checking bench for the bus arbiter
// Assumes: inputs change on the falling edge
// Notes: shared lines resolve in the peer model
`timescale 1ns/1ns
`default_nettype none
module test_host_multiproc_bus_arbitration;
  logic i_sys_clk, i_srst, i_rotating_priority_select, i_ack_drive_mode_bit, i_core_bus_want;
  logic i_core_is_dma, i_core_priority_req, i_access_done, i_host_bus_request_n;
  logic i_host_chip_select_n, prio_drive, o_bus_owner, o_bus_drive_en;
  logic [2:0] i_processor_index;
  logic [5:0] peer_want, o_peer_bus_request_n, o_peer_bus_request_oe;
  logic o_core_priority_override_n, o_core_priority_override_oe, o_host_bus_grant_n;
  logic o_host_bus_grant_oe, o_host_access_ack, o_host_access_ack_oe, o_host_access_pending;
  wire [5:0] i_peer_bus_request_n;
  wire i_core_priority_override_n, i_host_bus_grant_n;
  int num_errors = 0;
  int n_checks = 0;
  bus_arbiter bus_arbiter_inst (.i_sys_clk, .i_srst, .i_processor_index,
    .i_rotating_priority_select, .i_ack_drive_mode_bit, .i_core_bus_want, .i_core_is_dma,
    .i_core_priority_req, .i_access_done, .o_bus_owner, .o_bus_drive_en, .i_peer_bus_request_n,
    .o_peer_bus_request_n, .o_peer_bus_request_oe, .i_core_priority_override_n,
    .o_core_priority_override_n, .o_core_priority_override_oe, .i_host_bus_request_n,
    .i_host_chip_select_n, .i_host_bus_grant_n, .o_host_bus_grant_n, .o_host_bus_grant_oe,
    .o_host_access_ack, .o_host_access_ack_oe, .o_host_access_pending);
  peer_procs_model peer_procs_model_inst (.i_want(peer_want), .i_prio(prio_drive),
    .i_req_n(o_peer_bus_request_n), .i_req_oe(o_peer_bus_request_oe),
    .i_prio_oe(o_core_priority_override_oe), .i_prio_val(o_core_priority_override_n),
    .i_grant_n(o_host_bus_grant_n),
    .i_grant_oe(o_host_bus_grant_oe), .o_req_n(i_peer_bus_request_n),
    .o_prio_n(i_core_priority_override_n), .o_grant_n(i_host_bus_grant_n));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  task automatic rst(input logic [2:0] idx);
    i_srst = 1'b1;
    i_processor_index = idx;
    cyc(10);
    i_srst = 1'b0;
  endtask
  task automatic t_index;
    for (int k = 1; k <= 6; k++) begin
      rst(3'(k));
      chk("req_oe", 8'(6'h01 << (k - 1)), {2'h0, o_peer_bus_request_oe});
    end
  endtask
  task automatic t_prio;
    rst(3'h1);
    i_core_bus_want = 1'b1;
    cyc(1);
    peer_want = 6'h02;
    cyc(2);
    chk("fixed_owner", 8'h01, {7'h0, o_bus_owner});
    chk("req_lines", 8'h3C, {2'h0, i_peer_bus_request_n});
    {peer_want, i_core_bus_want, i_access_done} = 8'h01;
    cyc(2);
    i_access_done = 1'b0;
    i_rotating_priority_select = 1'b1;
    i_core_bus_want = 1'b1;
    cyc(1);
    peer_want = 6'h02;
    cyc(3);
    chk("rotate_owner", 8'h00, {7'h0, o_bus_owner});
    peer_want = 6'h00;
    cyc(3);
    chk("alone_owner", 8'h01, {7'h0, o_bus_owner});
    i_rotating_priority_select = 1'b0;
  endtask
  task automatic t_host;
    i_host_bus_request_n = 1'b0;
    #1 chk("drive_en", 8'h00, {7'h0, o_bus_drive_en});
    cyc(2);
    chk("grant", 8'h00, {7'h0, i_host_bus_grant_n});
    cyc(4);
    chk("grant_held", 8'h02, {6'h0, o_host_bus_grant_oe, o_host_bus_grant_n});
    chk("owner", 8'h00, {7'h0, o_bus_owner});
    i_host_chip_select_n = 1'b0;
    #1 chk("ack_wait", 8'h02, {6'h0, o_host_access_ack_oe, o_host_access_ack});
    i_access_done = 1'b1;
    cyc(1);
    chk("ack_od", 8'h01, {6'h0, o_host_access_ack_oe, o_host_access_ack});
    cyc(1);
    chk("ack_stays", 8'h01, {6'h0, o_host_access_ack_oe, o_host_access_ack});
    i_ack_drive_mode_bit = 1'b1;
    #1 chk("ack_ad", 8'h03, {6'h0, o_host_access_ack_oe, o_host_access_ack});
    i_host_chip_select_n = 1'b1;
    #1 chk("ack_off", 8'h00, {7'h0, o_host_access_ack_oe});
    {i_access_done, i_ack_drive_mode_bit, i_host_bus_request_n} = 3'h1;
    cyc(1);
    chk("grant_off", 8'h01, {7'h0, o_host_bus_grant_n});
  endtask
  task automatic t_preempt;
    i_core_is_dma = 1'b1;
    cyc(3);
    chk("dma_owner", 8'h01, {7'h0, o_bus_owner});
    prio_drive = 1'b1;
    cyc(2);
    chk("preempted", 8'h00, {7'h0, o_bus_owner});
    i_core_priority_req = 1'b1;
    #1 chk("prio_pull", 8'h01, {7'h0, o_core_priority_override_oe});
    cyc(1);
    {prio_drive, i_core_is_dma, i_core_bus_want, i_core_priority_req} = 4'h0;
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    {i_rotating_priority_select, i_ack_drive_mode_bit, i_core_bus_want, i_core_is_dma} = 4'h0;
    {i_core_priority_req, i_access_done, prio_drive, peer_want} = 9'h000;
    {i_host_bus_request_n, i_host_chip_select_n} = 2'h3;
    t_index;
    t_prio;
    t_host;
    t_preempt;
    report_and_stop;
  end
  initial begin
    repeat (3000) @(posedge i_sys_clk);
    num_errors++;
    report_and_stop;
  end
endmodule
`default_nettype wire
